// ===== rtl/casb_pkg.sv
// shared opcodes, condition codes, flag positions and timing counts for the exec subset
package casb_pkg;
    localparam int DATA_W = 16;
    localparam int TEN_BIT_IMMEDIATE_W = 10;
    localparam int FIVE_BIT_IMMEDIATE_W = 5;
    localparam int BIT_W = 4;
    localparam int REG_CNT_W = 4;
    localparam int SKIP_EXTRA_ONE_WORD = 1;
    localparam int SKIP_EXTRA_TWO_WORD = 2;
    localparam int BRANCH_EXTRA = 1;
    localparam int STALL_W = 2;

    // status flag positions inside the flag vector
    localparam int FLG_C = 0;
    localparam int FLG_Z = 1;
    localparam int FLG_OV = 2;
    localparam int FLG_N = 3;
    localparam int FLG_DC = 4;
    localparam int FLG_W = 5;
    localparam logic [FLG_W-1:0] FLAGS_RESET = 5'h00;
    localparam logic [FLG_W-1:0] MASK_ALL = 5'h1F;
    localparam logic [FLG_W-1:0] MASK_CNOVZ = 5'h0F;
    localparam logic [FLG_W-1:0] MASK_NZ = 5'h0A;
    localparam logic [FLG_W-1:0] MASK_NONE = 5'h00;
    localparam int DC_BIT = 3;

    typedef enum logic [3:0] {
        OP_ADD_WITH_CARRY_OP_FILE = 4'h0,
        OP_ADD_WITH_CARRY_OP_TEN_BIT_IMMEDIATE = 4'h1,
        OP_ASR_ONE = 4'h2,
        OP_ASR_BY_REG = 4'h3,
        OP_ASR_BY_FIVE_BIT_IMMEDIATE = 4'h4,
        OP_BRANCH = 4'h5,
        OP_BIT_TEST_SKIP_CLEAR_OP = 4'h6,
        OP_BIT_SET_OP = 4'h7,
        OP_BIT_CLEAR_OP = 4'h8,
        OP_BTG = 4'h9
    } casb_op_type;

    typedef enum logic [3:0] {
        CC_GE = 4'h0,
        CC_GT = 4'h1,
        CC_LE = 4'h2,
        CC_LT = 4'h3,
        CC_GEU = 4'h4,
        CC_GTU = 4'h5,
        CC_LEU = 4'h6,
        CC_LTU = 4'h7,
        CC_OV = 4'h8,
        CC_NOV = 4'h9,
        CC_ALWAYS = 4'hA
    } casb_cond_type;
endpackage

// ===== rtl/casb_alu.sv
// combinational adder, arithmetic shifter and single-bit unit
`timescale 1ns/1ns
module casb_alu #(
    parameter int DATA_W = casb_pkg::DATA_W
) (
    // operation and operands
    input wire casb_pkg::casb_op_type op_i,
    input wire logic [DATA_W-1:0] opnd_a_i,
    input wire logic [DATA_W-1:0] opnd_b_i,
    input wire logic [casb_pkg::TEN_BIT_IMMEDIATE_W-1:0] lit_i,
    input wire logic [casb_pkg::BIT_W-1:0] bit_pos_i,
    input wire logic carry_i,
    // result and new flag values
    output logic [DATA_W-1:0] result_o,
    output logic [casb_pkg::FLG_W-1:0] flags_o
);
    logic [DATA_W:0] sum;
    logic [DATA_W-1:0] addend;
    logic [casb_pkg::DC_BIT+1:0] dc_sum;
    logic [DATA_W-1:0] bit_mask;
    logic [casb_pkg::FIVE_BIT_IMMEDIATE_W-1:0] amount;

    // shift by up to 31; counts at or past the width leave only sign copies
    function automatic logic [DATA_W-1:0] arith_right_shift_op(input logic [DATA_W-1:0] v,
                                             input logic [casb_pkg::FIVE_BIT_IMMEDIATE_W-1:0] n);
        arith_right_shift_op = DATA_W'($signed(v) >>> n);
    endfunction

    always_comb
    begin
        addend = (op_i == casb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_IMMEDIATE) ? DATA_W'(lit_i) : opnd_b_i;
        sum = {1'b0, opnd_a_i} + {1'b0, addend} + {{DATA_W{1'b0}}, carry_i};
        dc_sum = {1'b0, opnd_a_i[casb_pkg::DC_BIT:0]} + {1'b0, addend[casb_pkg::DC_BIT:0]}
                 + {{(casb_pkg::DC_BIT+1){1'b0}}, carry_i};
        bit_mask = DATA_W'(1) << bit_pos_i;
        amount = (op_i == casb_pkg::OP_ASR_BY_REG) ?
                 casb_pkg::FIVE_BIT_IMMEDIATE_W'(opnd_b_i[casb_pkg::REG_CNT_W-1:0]) :
                 lit_i[casb_pkg::FIVE_BIT_IMMEDIATE_W-1:0];
        result_o = opnd_a_i;
        flags_o = '0;
        case (op_i)
            casb_pkg::OP_ADD_WITH_CARRY_OP_FILE, casb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_IMMEDIATE:
            begin
                result_o = sum[DATA_W-1:0];
                flags_o[casb_pkg::FLG_C] = sum[DATA_W];
                flags_o[casb_pkg::FLG_DC] = dc_sum[casb_pkg::DC_BIT+1];
                flags_o[casb_pkg::FLG_OV] = (opnd_a_i[DATA_W-1] == addend[DATA_W-1]) &&
                                            (sum[DATA_W-1] != opnd_a_i[DATA_W-1]);
            end
            casb_pkg::OP_ASR_ONE:
            begin
                result_o = arith_right_shift_op(opnd_a_i, casb_pkg::FIVE_BIT_IMMEDIATE_W'(1));
                flags_o[casb_pkg::FLG_C] = opnd_a_i[0];
            end
            casb_pkg::OP_ASR_BY_REG, casb_pkg::OP_ASR_BY_FIVE_BIT_IMMEDIATE:
                result_o = arith_right_shift_op(opnd_a_i, amount);
            casb_pkg::OP_BIT_SET_OP: result_o = opnd_a_i | bit_mask;
            casb_pkg::OP_BIT_CLEAR_OP: result_o = opnd_a_i & ~bit_mask;
            casb_pkg::OP_BTG: result_o = opnd_a_i ^ bit_mask;
            default: result_o = opnd_a_i;
        endcase
        flags_o[casb_pkg::FLG_N] = result_o[DATA_W-1];
        flags_o[casb_pkg::FLG_Z] = (result_o == '0);
    end
endmodule // casb_alu

// ===== rtl/casb_exec.sv
// execution unit for add-with-carry, arithmetic shifts, branches and bit ops
// Operation
// - file add-with-carry writes working register, one cycle
// - immediate add-with-carry adds ten-bit literal plus carry
// - single shift keeps sign, sets C N OV Z
// - register-count shift updates only N and Z
// - five-bit immediate shift, N Z only, one cycle
// - signed branches one cycle, two taken, flags kept
// - unsigned branches same timing, flags unchanged
// - overflow set/clear branches, same timing, flags kept
// - test bit, skip if clear, one cycle, two or three when skipping
`timescale 1ns/1ns
module casb_exec #(
    parameter int DATA_W = casb_pkg::DATA_W
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // decoded instruction issue
    input wire logic issue_valid_i,
    output logic issue_ready_o,
    input wire casb_pkg::casb_op_type op_i,
    input wire casb_pkg::casb_cond_type cond_i,
    input wire logic [DATA_W-1:0] opnd_a_i,
    input wire logic [DATA_W-1:0] opnd_b_i,
    input wire logic [casb_pkg::TEN_BIT_IMMEDIATE_W-1:0] lit_i,
    input wire logic [casb_pkg::BIT_W-1:0] bit_pos_i,
    input wire logic next_two_word_i,
    // result write-back
    output logic done_o,
    output logic result_we_o,
    output logic [DATA_W-1:0] result_o,
    // program flow
    output logic redirect_o,
    output logic skip_o,
    // status flags
    output logic [casb_pkg::FLG_W-1:0] flags_o
);
    typedef enum logic [2:0] {
        ST_RUN = 3'h1,
        ST_STALL = 3'h2,
        ST_LAST = 3'h4
    } casb_state_type;

    casb_state_type state_q;
    casb_state_type state_d;
    logic [casb_pkg::FLG_W-1:0] flags_q;
    logic [DATA_W-1:0] result_q;
    logic done_q;
    logic we_q;
    logic redirect_q;
    logic skip_q;
    logic [DATA_W-1:0] alu_result;
    logic [casb_pkg::FLG_W-1:0] alu_flags;
    logic [casb_pkg::FLG_W-1:0] upd_mask;
    logic accept;
    logic taken;
    logic skipping;
    logic [casb_pkg::STALL_W-1:0] extra;

    // refused at elaboration: the shifter and bit decoder assume these widths
    if (DATA_W <= casb_pkg::REG_CNT_W || DATA_W > 32)
    begin : g_bad_data_w
        $error("casb_exec: DATA_W out of range");
    end
    if (DATA_W < (1 << casb_pkg::BIT_W))
    begin : g_narrow_data_w
        $error("casb_exec: DATA_W too narrow for bit position field");
    end

    // condition evaluation from the held flags
    function automatic logic cond_true(input casb_pkg::casb_cond_type cc,
                                       input logic [casb_pkg::FLG_W-1:0] f);
        logic c;
        logic z;
        logic n;
        logic v;
        c = f[casb_pkg::FLG_C];
        z = f[casb_pkg::FLG_Z];
        n = f[casb_pkg::FLG_N];
        v = f[casb_pkg::FLG_OV];
        case (cc)
            casb_pkg::CC_GE: cond_true = (n == v);
            casb_pkg::CC_GT: cond_true = !z && (n == v);
            casb_pkg::CC_LE: cond_true = z || (n != v);
            casb_pkg::CC_LT: cond_true = (n != v);
            casb_pkg::CC_GEU: cond_true = c;
            casb_pkg::CC_GTU: cond_true = c && !z;
            casb_pkg::CC_LEU: cond_true = !c || z;
            casb_pkg::CC_LTU: cond_true = !c;
            casb_pkg::CC_OV: cond_true = v;
            casb_pkg::CC_NOV: cond_true = !v;
            casb_pkg::CC_ALWAYS: cond_true = 1'b1;
            default: cond_true = 1'b0;
        endcase
    endfunction

    casb_alu #(
        .DATA_W(DATA_W)
    ) u_alu (
        .op_i(op_i),
        .opnd_a_i(opnd_a_i),
        .opnd_b_i(opnd_b_i),
        .lit_i(lit_i),
        .bit_pos_i(bit_pos_i),
        .carry_i(flags_q[casb_pkg::FLG_C]),
        .result_o(alu_result),
        .flags_o(alu_flags)
    );

    // new instructions are held off only while a flush is in progress
    assign issue_ready_o = (state_q == ST_RUN);
    assign accept = issue_valid_i && issue_ready_o;

    always_comb
    begin
        taken = 1'b0;
        skipping = 1'b0;
        upd_mask = casb_pkg::MASK_NONE;
        case (op_i)
            casb_pkg::OP_ADD_WITH_CARRY_OP_FILE, casb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_IMMEDIATE:
                upd_mask = casb_pkg::MASK_ALL;
            casb_pkg::OP_ASR_ONE:
                upd_mask = casb_pkg::MASK_CNOVZ;
            casb_pkg::OP_ASR_BY_REG, casb_pkg::OP_ASR_BY_FIVE_BIT_IMMEDIATE:
                upd_mask = casb_pkg::MASK_NZ;
            casb_pkg::OP_BRANCH:
                taken = cond_true(cond_i, flags_q);
            casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP:
                skipping = !opnd_a_i[bit_pos_i];
            default:
                upd_mask = casb_pkg::MASK_NONE;
        endcase
        // a skipped two-word instruction has both its words flushed
        if (skipping)
            extra = next_two_word_i ? casb_pkg::STALL_W'(casb_pkg::SKIP_EXTRA_TWO_WORD) :
                    casb_pkg::STALL_W'(casb_pkg::SKIP_EXTRA_ONE_WORD);
        else if (taken)
            extra = casb_pkg::STALL_W'(casb_pkg::BRANCH_EXTRA);
        else
            extra = '0;
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_RUN:
                if (accept && extra == casb_pkg::STALL_W'(casb_pkg::SKIP_EXTRA_TWO_WORD))
                    state_d = ST_STALL;
                else if (accept && extra != '0)
                    state_d = ST_LAST;
            ST_STALL: state_d = ST_LAST;
            ST_LAST: state_d = ST_RUN;
            default: state_d = ST_RUN;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            state_q <= ST_RUN;
        else
            state_q <= state_d;
    end

    // branches, skips and bit ops leave the flags untouched through the mask
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            flags_q <= casb_pkg::FLAGS_RESET;
        else if (accept)
            flags_q <= (flags_q & ~upd_mask) | (alu_flags & upd_mask);
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            result_q <= '0;
            we_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            done_q <= accept;
            we_q <= accept && op_i != casb_pkg::OP_BRANCH && op_i != casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP;
            if (accept)
                result_q <= alu_result;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            redirect_q <= 1'b0;
            skip_q <= 1'b0;
        end
        else
        begin
            redirect_q <= accept && taken;
            skip_q <= accept && skipping;
        end
    end

    assign done_o = done_q;
    assign result_we_o = we_q;
    assign result_o = result_q;
    assign redirect_o = redirect_q;
    assign skip_o = skip_q;
    assign flags_o = flags_q;
endmodule // casb_exec

// ===== verif/casb_exec_chk.sv
// concurrent checks on issue, write-back, stall and flag behaviour of the exec unit
`timescale 1ns/1ns
module casb_exec_chk #(
    parameter int DATA_W = casb_pkg::DATA_W
) (
    // watched ports
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic issue_valid_i,
    input wire logic issue_ready_o,
    input wire casb_pkg::casb_op_type op_i,
    input wire logic [DATA_W-1:0] opnd_a_i,
    input wire logic [DATA_W-1:0] opnd_b_i,
    input wire logic [casb_pkg::BIT_W-1:0] bit_pos_i,
    input wire logic next_two_word_i,
    input wire logic done_o,
    input wire logic result_we_o,
    input wire logic [DATA_W-1:0] result_o,
    input wire logic redirect_o,
    input wire logic skip_o,
    input wire logic [casb_pkg::FLG_W-1:0] flags_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!resetn_i);
    logic acc;
    logic skip_sel;
    assign acc = issue_valid_i && issue_ready_o;
    assign skip_sel = acc && op_i == casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP && !opnd_a_i[bit_pos_i];

    done_latency_a: assert property (acc |=> done_o)
        else $error("done missing one cycle after accept");
    no_stray_done_a: assert property (!acc |=> !done_o)
        else $error("done without an accepted op");
    add_with_carry_op_sum_a: assert property (acc && op_i == casb_pkg::OP_ADD_WITH_CARRY_OP_FILE |=>
        result_we_o && result_o == DATA_W'($past(opnd_a_i) + $past(opnd_b_i)
        + $past(flags_o[casb_pkg::FLG_C])))
        else $error("add with carry sum wrong");
    asr_one_a: assert property (acc && op_i == casb_pkg::OP_ASR_ONE |=>
        result_o == {$past(opnd_a_i[DATA_W-1]), $past(opnd_a_i[DATA_W-1:1])}
        && flags_o[casb_pkg::FLG_C] == $past(opnd_a_i[0]) && !flags_o[casb_pkg::FLG_OV])
        else $error("single shift result or flags wrong");
    shift_nz_a: assert property (acc && op_i inside {casb_pkg::OP_ASR_BY_REG,
        casb_pkg::OP_ASR_BY_FIVE_BIT_IMMEDIATE} |=> (flags_o & ~casb_pkg::MASK_NZ) ==
        ($past(flags_o) & ~casb_pkg::MASK_NZ))
        else $error("multi shift touched flags other than N and Z");
    branch_keep_a: assert property (acc && op_i == casb_pkg::OP_BRANCH |=>
        !result_we_o && !skip_o && $stable(flags_o))
        else $error("branch wrote a result or changed flags");
    taken_stall_a: assert property (redirect_o |-> !issue_ready_o ##1 issue_ready_o)
        else $error("taken branch stall not one cycle");
    skip_one_a: assert property (skip_sel && !next_two_word_i |=>
        skip_o && !issue_ready_o ##1 issue_ready_o)
        else $error("skip over one word not two cycles");
    skip_two_a: assert property (skip_sel && next_two_word_i |=>
        (skip_o && !issue_ready_o) ##1 !issue_ready_o ##1 issue_ready_o)
        else $error("skip over two words not three cycles");
    no_skip_a: assert property (acc && op_i == casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP &&
        opnd_a_i[bit_pos_i] |=> !skip_o && !result_we_o && issue_ready_o)
        else $error("bit test skipped on a set bit");
    bit_only_a: assert property (acc && op_i inside {casb_pkg::OP_BIT_SET_OP,
        casb_pkg::OP_BIT_CLEAR_OP, casb_pkg::OP_BTG} |=> result_we_o && $stable(flags_o)
        && ((result_o ^ $past(opnd_a_i)) & ~(DATA_W'(1) << $past(bit_pos_i))) == '0)
        else $error("bit op changed other bits or flags");
endmodule // casb_exec_chk

bind casb_exec casb_exec_chk #(.DATA_W(DATA_W)) u_chk (.ref_clk_i, .resetn_i, .issue_valid_i,
    .issue_ready_o, .op_i, .opnd_a_i, .opnd_b_i, .bit_pos_i, .next_two_word_i, .done_o,
    .result_we_o, .result_o, .redirect_o, .skip_o, .flags_o);

// ===== verif/testbench.sv
// self-checking bench: reference model fills a queue, a monitor compares results
`timescale 1ns/1ns
module testbench;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic issue_valid_i = 1'b0;
    casb_pkg::casb_op_type op_i = casb_pkg::OP_ADD_WITH_CARRY_OP_FILE;
    casb_pkg::casb_cond_type cond_i = casb_pkg::CC_GE;
    logic [15:0] opnd_a_i = 16'h0000;
    logic [15:0] opnd_b_i = 16'h0000;
    logic [9:0] lit_i = 10'h000;
    logic [3:0] bit_pos_i = 4'h0;
    logic next_two_word_i = 1'b0;
    logic issue_ready_o, done_o, result_we_o, redirect_o, skip_o;
    logic [15:0] result_o;
    logic [4:0] flags_o;
    logic [4:0] mflags = 5'h00;
    logic [1:0] stall = 2'h0;
    logic [23:0] e;
    logic [23:0] exp_q[$];
    logic [31:0] rv, rw;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 38;

    always #4 ref_clk_i = ~ref_clk_i;

    casb_exec uut (.ref_clk_i, .resetn_i, .issue_valid_i, .issue_ready_o, .op_i, .cond_i,
        .opnd_a_i, .opnd_b_i, .lit_i, .bit_pos_i, .next_two_word_i, .done_o, .result_we_o,
        .result_o, .redirect_o, .skip_o, .flags_o);

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic reset_dut();
        @(negedge ref_clk_i);
        issue_valid_i = 1'b0;
        resetn_i = 1'b0;
        mflags = 5'h00;
        stall = 2'h0;
        exp_q.delete();
        repeat (6) @(negedge ref_clk_i);
        check("reset state", {1'b0, issue_ready_o, done_o, result_o, flags_o}, 24'h400000);
        resetn_i = 1'b1;
    endtask

    // holds the request while refused, then notes the expected outcome
    task automatic issue(input casb_pkg::casb_op_type op, input casb_pkg::casb_cond_type cc,
            input logic [15:0] a, input logic [15:0] b, input logic [9:0] lit,
            input logic [3:0] bp, input logic two);
        logic [16:0] s;
        logic [15:0] r, bb;
        logic [10:0] cv;
        logic [4:0] f;
        logic [1:0] w;
        logic t, we;
        @(negedge ref_clk_i);
        op_i = op;
        cond_i = cc;
        opnd_a_i = a;
        opnd_b_i = b;
        lit_i = lit;
        bit_pos_i = bp;
        next_two_word_i = two;
        issue_valid_i = 1'b1;
        w = 2'h0;
        while (issue_ready_o !== 1'b1 && w < 2'h3)
        begin
            @(negedge ref_clk_i);
            w++;
        end
        check("stall cycles", 24'(w), 24'(stall));
        f = mflags;
        r = a;
        we = 1'b1;
        t = 1'b0;
        bb = (op == casb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_IMMEDIATE) ? {6'h00, lit} : b;
        cv = {1'b1, !f[2], f[2], !f[0], !f[0] | f[1], f[0] & !f[1], f[0], f[3] != f[2],
            f[1] | (f[3] != f[2]), !f[1] & (f[3] == f[2]), f[3] == f[2]};
        case (op)
            casb_pkg::OP_ADD_WITH_CARRY_OP_FILE, casb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_IMMEDIATE:
            begin
                s = a + bb + f[0];
                r = s[15:0];
                // digit carry uses the carry that went in, so it is taken first
                f[4] = (a[3:0] + bb[3:0] + f[0]) > 5'h0F;
                f[0] = s[16];
                f[2] = (a[15] == bb[15]) && (r[15] != a[15]);
            end
            casb_pkg::OP_ASR_ONE:
            begin
                r = {a[15], a[15:1]};
                f[0] = a[0];
                f[2] = 1'b0;
            end
            casb_pkg::OP_ASR_BY_REG: r = $signed(a) >>> b[3:0];
            casb_pkg::OP_ASR_BY_FIVE_BIT_IMMEDIATE: r = $signed(a) >>> lit[4:0];
            casb_pkg::OP_BIT_SET_OP: r = a | (16'h0001 << bp);
            casb_pkg::OP_BIT_CLEAR_OP: r = a & ~(16'h0001 << bp);
            casb_pkg::OP_BTG: r = a ^ (16'h0001 << bp);
            casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP:
            begin
                we = 1'b0;
                t = !a[bp];
            end
            default:
            begin
                we = 1'b0;
                t = cv[cc];
            end
        endcase
        if (op <= casb_pkg::OP_ASR_BY_FIVE_BIT_IMMEDIATE)
        begin
            f[1] = (r == 16'h0000);
            f[3] = r[15];
        end
        exp_q.push_back({we, op == casb_pkg::OP_BRANCH && t, op == casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP && t, r, f});
        mflags = f;
        stall = !t ? 2'h0 : (op == casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP && two) ? 2'h2 : 2'h1;
    endtask

    always @(negedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            end_of_test();
        end
        else if (done_o === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("done without issue", 24'h1, 24'h0);
            else
            begin
                e = exp_q.pop_front();
                check("done outputs", {result_we_o, redirect_o, skip_o,
                    e[23] ? result_o : e[20:5], flags_o}, e);
            end
        end
    end

    initial
    begin
        reset_dut();
        issue(casb_pkg::OP_ADD_WITH_CARRY_OP_FILE, casb_pkg::CC_GE, 16'hFFFF, 16'h0001, 10'h000, 4'h0, 1'b0);
        issue(casb_pkg::OP_ADD_WITH_CARRY_OP_TEN_BIT_IMMEDIATE, casb_pkg::CC_GE, 16'h7FFF, 16'h0000, 10'h3FF, 4'h0, 1'b0);
        issue(casb_pkg::OP_ASR_BY_FIVE_BIT_IMMEDIATE, casb_pkg::CC_GE, 16'h8000, 16'h0000, 10'h01F, 4'h0, 1'b0);
        issue(casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP, casb_pkg::CC_GE, 16'h7FFF, 16'h0000, 10'h000, 4'hF, 1'b1);
        issue(casb_pkg::OP_BIT_TEST_SKIP_CLEAR_OP, casb_pkg::CC_GE, 16'h7FFF, 16'h0000, 10'h000, 4'hF, 1'b0);
        issue(casb_pkg::OP_BRANCH, casb_pkg::CC_ALWAYS, 16'h0000, 16'h0000, 10'h000, 4'h0, 1'b0);
        issue(casb_pkg::OP_BIT_SET_OP, casb_pkg::CC_GE, 16'h0000, 16'h0000, 10'h000, 4'hF, 1'b0);
        $display("test directed corners done");
        // random mix walks every opcode and condition with back-to-back issue
        repeat (400)
        begin
            rv = $random(seed);
            rw = $random(seed);
            issue(casb_pkg::casb_op_type'(rv[31:16] % 10),
                casb_pkg::casb_cond_type'(rw[31:26] % 11),
                rv[15:0], rw[15:0], rv[25:16], rw[19:16], rw[20]);
        end
        @(negedge ref_clk_i);
        issue_valid_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        check("pending results", 24'(exp_q.size()), 24'h0);
        $display("test random mix done");
        reset_dut();
        issue(casb_pkg::OP_ADD_WITH_CARRY_OP_FILE, casb_pkg::CC_GE, 16'h1234, 16'h0F0F, 10'h000, 4'h0, 1'b0);
        @(negedge ref_clk_i);
        issue_valid_i = 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check("results after reset", 24'(exp_q.size()), 24'h0);
        $display("test second reset done");
        end_of_test();
    end
endmodule // testbench
